/* core/tfdw_port.sv */
// write side of the host bus with the fifo-direct select
// assumes host strobes, address, data and select come straight from pins
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1 - select high: ignore upper address, write fifo
// R2 - 32-bit data bus, optional 16-bit width
// R3 - 16-bit mode: ignore upper data half
// R4 - keep a[2:1], drop a[7:3] in fifo mode
// R5 - cycle spans joint strobe assertion, any order
// R6 - host holds strobes jointly low 32 ns
// R7 - host keeps a 13 ns gap between cycles
// R8 - select low: normal address decode to registers
//
// timing of one write, counted in core clock edges:
//   the strobes pass two flops, so a joint low on the pins is seen
//   by the cycle tracker two edges after it appears
//   address and select are latched on the edge that opens the cycle,
//   which is why the host must hold them from the strobe fall onward
//   data is re-sampled on every edge while the joint low is seen, so
//   the last word on the bus before the strobes rise is the one kept
//   the close is seen two edges after the first strobe rises, and the
//   one-cycle valid pulse follows on the next edge
//
// hazards and limits:
//   a joint low shorter than one clock may be missed entirely; the
//   host's least assertion time keeps every joint low visible; its
//   13 ns gap is under one clock, so two cycles may merge
//   data and address cross as plain bits through two flops each; this
//   is safe only because the host keeps them steady around the strobes
//   the width strap is read at the close of each cycle, so changing it
//   while a cycle is open affects that cycle's word
//   the register route carries a plain strobe and address; the
//   registers themselves live elsewhere
//
module tfdw_port
  import tfdw_pkg::*;
(
  input  wire logic                  clock,           // core clock
  input  wire logic                  resetn,          // async reset, low
  input  wire logic                  chip_select_n,   // host chip select
  input  wire logic                  write_strobe_n,  // host write strobe
  input  wire logic                  fifo_select,     // fifo-direct select
  input  wire logic [ADDR_W-1:0]     addr,            // host a[7:1]
  input  wire logic [DATA_W-1:0]     data_in,         // host data bus
  input  wire logic                  bus_16bit,       // 16-bit width strap
  output var  tfdw_fifo_word_s       fifo_write,      // fifo word
  output logic                       fifo_write_valid,// one-cycle pulse
  output var  tfdw_reg_write_s       reg_write,       // register write
  output logic                       reg_write_valid  // one-cycle pulse
);
  logic [1:0] strobe_sync1;          // first synchroniser stage
  logic [1:0] strobe_sync2;          // second synchroniser stage
  logic       fsel_sync1;            // select, first stage
  logic       fsel_sync2;            // select, second stage
  logic       width_sync1;           // width, first stage
  logic       width_sync2;           // width, second stage
  logic [ADDR_W-1:0] addr_sync1;     // address first stage
  logic [ADDR_W-1:0] addr_sync2;     // address second stage
  logic [DATA_W-1:0] data_sync1;     // data first stage
  logic [DATA_W-1:0] data_sync2;     // data second stage
  logic [DATA_W-1:0] data_hold;      // last data seen during the cycle
  logic [ADDR_W-1:0] addr_hold;      // address latched at cycle start
  logic       fsel_hold;             // select latched at cycle start
  tfdw_state_e state;                // cycle tracker
  tfdw_state_e next_state;           // next tracker state

  // both strobes low means the cycle is live
  wire logic joint_low   = (strobe_sync2 == 2'h0);        // see R5
  wire logic cycle_start = (state == TFDW_IDLE) && joint_low;
  wire logic cycle_end   = (state == TFDW_ACTIVE) && !joint_low; // see R5
  // upper half masked when narrow
  wire logic [DATA_W-1:0] data_masked = width_sync2 ?
    {{(DATA_W-HALF_W){1'b0}}, data_hold[HALF_W-1:0]} : data_hold; // see R3
  wire logic do_fifo = cycle_end && fsel_hold;             // see R1
  wire logic do_reg  = cycle_end && !fsel_hold;            // see R8

  always_comb begin
    next_state = state;
    case (state)
      TFDW_IDLE:   if (joint_low) next_state = TFDW_ACTIVE;
      TFDW_ACTIVE: if (!joint_low) next_state = TFDW_IDLE;
      default:     next_state = TFDW_IDLE;
    endcase
  end

  // two-flop synchronisers for every pin but resetn
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strobe_sync1 <= SYNC_IDLE;
      strobe_sync2 <= SYNC_IDLE;
      fsel_sync1   <= 1'b0;
      fsel_sync2   <= 1'b0;
      width_sync1  <= 1'b0;
      width_sync2  <= 1'b0;
      addr_sync1   <= ADDR_RST;
      addr_sync2   <= ADDR_RST;
      data_sync1   <= DATA_RST;
      data_sync2   <= DATA_RST;
    end else begin
      strobe_sync1 <= {chip_select_n, write_strobe_n};
      strobe_sync2 <= strobe_sync1;
      fsel_sync1   <= fifo_select;
      fsel_sync2   <= fsel_sync1;
      width_sync1  <= bus_16bit;
      width_sync2  <= width_sync1;
      addr_sync1   <= addr;
      addr_sync2   <= addr_sync1;
      data_sync1   <= data_in;
      data_sync2   <= data_sync1;
    end
  end

  // track the cycle; data follows the bus until the strobes rise
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state     <= TFDW_IDLE;
      data_hold <= DATA_RST;
      addr_hold <= ADDR_RST;
      fsel_hold <= 1'b0;
    end else begin
      state <= next_state;
      if (joint_low) data_hold <= data_sync2;  // data set up before rise
      if (cycle_start) begin
        addr_hold <= addr_sync2;
        fsel_hold <= fsel_sync2;
      end
    end
  end

  // deliver the word when the cycle closes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fifo_write       <= '0;
      fifo_write_valid <= 1'b0;
      reg_write        <= '0;
      reg_write_valid  <= 1'b0;
    end else begin
      fifo_write_valid <= do_fifo;                         // see R1
      reg_write_valid  <= do_reg;                          // see R8
      if (do_fifo) begin
        fifo_write.data <= data_masked;                    // see R2
        fifo_write.word <= addr_hold[WORD_SEL_W-1:0];      // see R4
      end
      if (do_reg) begin
        reg_write.data <= data_masked;
        reg_write.addr <= addr_hold;
      end
    end
  end

  // assertions
  chk_fifo_on_end: assert property (@(posedge clock) disable iff (!resetn)
    (state == TFDW_ACTIVE && !joint_low && fsel_hold) |=> fifo_write_valid)
    else $error("fifo write missing at cycle end"); // see R1
  chk_reg_on_end: assert property (@(posedge clock) disable iff (!resetn)
    (state == TFDW_ACTIVE && !joint_low && !fsel_hold) |=> reg_write_valid)
    else $error("register write missing at cycle end"); // see R8
  chk_no_both: assert property (@(posedge clock) disable iff (!resetn)
    !(fifo_write_valid && reg_write_valid))
    else $error("fifo and register write together"); // see R1
  chk_half_mask: assert property (@(posedge clock) disable iff (!resetn)
    (fifo_write_valid && width_sync2 && $stable(width_sync2))
      |-> fifo_write.data[DATA_W-1:HALF_W] == '0)
    else $error("upper half not masked"); // see R3
  chk_word_sel: assert property (@(posedge clock) disable iff (!resetn)
    do_fifo |=> fifo_write.word == $past(addr_hold[WORD_SEL_W-1:0]))
    else $error("word select not kept"); // see R4
  chk_full_data: assert property (@(posedge clock) disable iff (!resetn)
    (do_fifo && !width_sync2) |=> fifo_write.data == $past(data_hold))
    else $error("32-bit data altered"); // see R2
  chk_start_req: assert property (@(posedge clock) disable iff (!resetn)
    $rose(fifo_write_valid) |-> $past(state == TFDW_ACTIVE))
    else $error("write without joint assertion"); // see R5
  chk_one_pulse: assert property (@(posedge clock) disable iff (!resetn)
    fifo_write_valid |=> !fifo_write_valid)
    else $error("fifo pulse longer than one cycle"); // see R5

  // register route keeps the full address latched at cycle start
  chk_reg_addr: assert property (@(posedge clock) disable iff (!resetn)
    do_reg |=> reg_write.addr == $past(addr_hold))
    else $error("register address not kept"); // see R8

  // register route carries the full word in 32-bit mode
  chk_reg_data: assert property (@(posedge clock) disable iff (!resetn)
    (do_reg && !width_sync2) |=> reg_write.data == $past(data_hold))
    else $error("register data altered"); // see R8

  // fifo word stands untouched between writes
  chk_fifo_steady: assert property (@(posedge clock) disable iff (!resetn)
    !fifo_write_valid |-> $stable(fifo_write))
    else $error("fifo word changed without a write"); // see R1

  // register word stands untouched between writes
  chk_reg_steady: assert property (@(posedge clock) disable iff (!resetn)
    !reg_write_valid |-> $stable(reg_write))
    else $error("register word changed without a write"); // see R8

  // register write pulse lasts a single cycle
  chk_reg_pulse: assert property (@(posedge clock) disable iff (!resetn)
    reg_write_valid |=> !reg_write_valid)
    else $error("register pulse longer than one cycle"); // see R5

  // a fifo write only follows a closed cycle
  chk_end_idle: assert property (@(posedge clock) disable iff (!resetn)
    fifo_write_valid |-> state == TFDW_IDLE)
    else $error("fifo write while cycle open"); // see R5

  // a register write only follows a closed cycle
  chk_reg_idle: assert property (@(posedge clock) disable iff (!resetn)
    reg_write_valid |-> state == TFDW_IDLE)
    else $error("register write while cycle open"); // see R5

  // a register write needs a cycle that was open
  chk_reg_start: assert property (@(posedge clock) disable iff (!resetn)
    $rose(reg_write_valid) |-> $past(state == TFDW_ACTIVE))
    else $error("register write without joint assertion"); // see R5

  // fifo route taken only with the select latched high
  chk_fifo_sel: assert property (@(posedge clock) disable iff (!resetn)
    fifo_write_valid |-> $past(fsel_hold))
    else $error("fifo write without select"); // see R1

  // register route taken only with the select latched low
  chk_reg_sel: assert property (@(posedge clock) disable iff (!resetn)
    reg_write_valid |-> !$past(fsel_hold))
    else $error("register write with select high"); // see R8
endmodule : tfdw_port
`default_nettype wire

/* core/tfdw_pkg.sv */
// package for the transmit-fifo direct write port
// assumes a single 40 MHz core clock; host strobes arrive asynchronously
package tfdw_pkg;
  localparam int          DATA_W      = 32;       // full data bus width
  localparam int          HALF_W      = 16;       // width kept in 16-bit mode
  localparam int          ADDR_W      = 7;        // address lines a[7:1]
  localparam int          WORD_SEL_W  = 2;        // a[2:1] word select
  localparam int          CLK_PS      = 25000;    // clock period in ps
  localparam int          T_ASSERT_NS = 32;       // least joint assertion
  localparam int          T_DEASS_NS  = 13;       // least gap between cycles
  // fewest cycles the sampled strobes must stay seen low, rounded down, at least 1
  localparam int          ASSERT_CYC  =
    ((T_ASSERT_NS * 1000) / CLK_PS) < 1 ? 1 : (T_ASSERT_NS * 1000) / CLK_PS;
  localparam logic [1:0]  SYNC_IDLE   = 2'h3;     // strobes idle high
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;  // data reset value
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;          // address reset

  // one captured host write
  typedef struct packed {
    logic [DATA_W-1:0]     data;   // written word
    logic [WORD_SEL_W-1:0] word;   // a[2:1]
  } tfdw_fifo_word_s;

  typedef struct packed {
    logic [DATA_W-1:0] data;       // written word
    logic [ADDR_W-1:0] addr;       // a[7:1]
  } tfdw_reg_write_s;

  // write cycle tracker
  typedef enum logic [0:0] {
    TFDW_IDLE   = 1'b0,            // waiting for a joint assertion
    TFDW_ACTIVE = 1'b1             // cycle in progress
  } tfdw_state_e;
endpackage : tfdw_pkg

/* dv/tfdw_host.sv */
// host processor model driving the fifo-direct write port
// assumes the bench calls put at a falling clock edge
`timescale 1ns/100ps
`default_nettype none
module tfdw_host
  import tfdw_pkg::*;
(
  input  wire logic              clock, // core clock
  output var  logic              cs_n,  // chip select
  output var  logic              wr_n,  // write strobe
  output var  logic              fsel,  // fifo-direct select
  output var  logic [ADDR_W-1:0] a,     // address a[7:1]
  output var  logic [DATA_W-1:0] d,     // data bus
  output var  logic              b16    // width strap
);
  // strobes idle high, bus quiet
  initial {cs_n, wr_n, fsel, a, d, b16} = {2'h3, 41'h0};

  // one write; o picks which strobe falls and which rises first
  task automatic put(input logic f, input logic [ADDR_W-1:0] ad,
                     input logic [DATA_W-1:0] dt, input logic w,
                     input logic [1:0] o);
    {fsel, a, d, b16} = {f, ad, dt, w};
    repeat (3) @(negedge clock);
    if (o[0]) cs_n = 1'b0; else wr_n = 1'b0;
    @(negedge clock);
    {cs_n, wr_n} = 2'h0;
    repeat (4) @(negedge clock);
    if (o[1]) cs_n = 1'b1; else wr_n = 1'b1;
    @(negedge clock);
    {cs_n, wr_n} = 2'h3;
    {fsel, a, d} = ~{fsel, a, d};  // released bus shows no old value
    repeat (2) @(negedge clock);
  endtask : put
endmodule : tfdw_host
`default_nettype wire

/* dv/tx_fifo_direct_write_port_test.sv */
// self-checking bench for the fifo-direct write port
// assumes the host model drives every bus pin at the falling edge
`timescale 1ns/100ps
`default_nettype none
module tx_fifo_direct_write_port_test;
  import tfdw_pkg::*;
  logic              clock, resetn; // clock, reset
  logic              cs_n, wr_n;    // host strobes
  logic              fsel, b16;     // select, width
  logic [ADDR_W-1:0] a;             // host address
  logic [DATA_W-1:0] d;             // host data
  tfdw_fifo_word_s   fw;            // fifo output
  tfdw_reg_write_s   rw;            // register output
  logic              fv, rv;        // output pulses
  logic [39:0]       q[$];          // expected results
  int                n_errors, checks, seed;

  tfdw_host host (.clock(clock), .cs_n(cs_n), .wr_n(wr_n), .fsel(fsel),
    .a(a), .d(d), .b16(b16));
  tfdw_port uut (.clock(clock), .resetn(resetn), .chip_select_n(cs_n),
    .write_strobe_n(wr_n), .fifo_select(fsel), .addr(a), .data_in(d),
    .bus_16bit(b16), .fifo_write(fw), .fifo_write_valid(fv),
    .reg_write(rw), .reg_write_valid(rv));

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // compare each output pulse with the oldest note, mid-cycle when settled
  always @(negedge clock) begin
    if (fv || rv) begin
      if (q.size() == 0) chk({39'h0, 1'b1}, 40'h0);
      else chk(fv ? {1'b1, 5'h00, fw} : {1'b0, rw}, q.pop_front());
    end
  end

  // fifo writes, register writes, then a mix
  initial begin
    logic [31:0]       r, dt;
    logic              f, w;
    logic [1:0]        o;
    logic [ADDR_W-1:0] ad;
    resetn = 1'b0;
    n_errors = 0;
    checks = 0;
    seed = 80829;
    repeat (20) @(negedge clock);
    resetn = 1'b1;
    for (int t = 0; t < 3; t++) begin
      for (int i = 0; i < 16; i++) begin
        r = $random(seed);
        dt = $random(seed);
        f = (t == 2) ? r[0] : (t == 0);
        w = f & r[1];
        o = r[3:2];
        ad = r[10:4];
        q.push_back(f ? {1'b1, 5'h00, w ? {16'h0000, dt[15:0]} : dt,
          ad[1:0]} : {1'b0, dt, ad});
        host.put(f, ad, dt, w, o);
      end
      $display("test %0d done", t);
    end
    repeat (10) @(negedge clock);
    chk(40'(q.size()), 40'h0);
    conclude();
  end

  // cut a hang short: 48 writes of about 11 cycles each
  initial begin
    repeat (4000) @(posedge clock);
    n_errors++;
    conclude();
  end
endmodule : tx_fifo_direct_write_port_test
`default_nettype wire
